// [core/cyclic_step_selector_pkg.sv]
// Constants used by the cyclic step selector design; its bench uses its own literals
package cyclic_step_selector_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_INST = 2;            // Instances A and B
  localparam int unsigned NUM_POS = 4;             // Most position outputs per instance
  localparam int unsigned INST_A = 0;
  localparam int unsigned INST_B = 1;

  typedef logic [1:0] pos_t;                        // Position index, 0 = first output
  typedef logic [1:0] cnt_code_t;                   // Output count setting
  typedef logic [3:0] onehot_t;                     // Position outputs, bit k = position k+1

  // ----------------------------------------------------------------
  // Output count setting codes
  // ----------------------------------------------------------------
  localparam cnt_code_t CNT_DEFAULT = 2'h0;         // Not configured, behaves as three
  localparam cnt_code_t CNT_TWO = 2'h1;
  localparam cnt_code_t CNT_THREE = 2'h2;
  localparam cnt_code_t CNT_FOUR = 2'h3;

  // ----------------------------------------------------------------
  // Reset, factory and last-position values
  // ----------------------------------------------------------------
  localparam pos_t POS_FIRST = 2'h0;                // Factory default position
  localparam pos_t LAST_TWO = 2'h1;
  localparam pos_t LAST_THREE = 2'h2;
  localparam pos_t LAST_FOUR = 2'h3;
  localparam onehot_t ONEHOT_RST = 4'h0;            // Outputs quiet until restore completes
  localparam logic STEP_PREV_RST = 1'b1;            // A step held through reset is not an edge

  // Sequencer states
  typedef enum logic {
    ST_RESTORE,
    ST_RUN
  } seq_state_e;

endpackage : cyclic_step_selector_pkg

// [core/cyclic_step_selector.sv]
// Two independent cyclic step selectors with non-volatile position keeping
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Summary of operation
// - Two identical independent selectors A and B, each one step input.
// - Each selector has its own output count setting: two, three or four.
// - An unconfigured selector uses three position outputs.
// - Each step moves to the next enabled position, ascending one to four.
// - Stepping from the last enabled position returns to the first.
// - Factory default selects the first position, only output one active.
// - Selected position is kept in non-volatile storage across power loss.
// - Output k active exactly at position k; three, four only if enabled.
// --------------------------------------------------------------------

module cyclic_step_selector (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Step inputs from the programmable logic map
  input wire logic i_step_a,
  input wire logic i_step_b,
  // Output count settings
  input wire logic [1:0] i_cnt_a,
  input wire logic [1:0] i_cnt_b,
  // Non-volatile store, read side
  input wire logic i_nv_valid,
  input wire logic [1:0] i_nv_pos_a,
  input wire logic [1:0] i_nv_pos_b,
  // Non-volatile store, write side
  output logic o_nv_wr,
  output logic [1:0] o_nv_pos_a,
  output logic [1:0] o_nv_pos_b,
  // Selector A position outputs
  output logic o_sel_a_pos1,
  output logic o_sel_a_pos2,
  output logic o_sel_a_pos3,
  output logic o_sel_a_pos4,
  // Selector B position outputs
  output logic o_sel_b_pos1,
  output logic o_sel_b_pos2,
  output logic o_sel_b_pos3,
  output logic o_sel_b_pos4
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Last enabled position for a count setting
  function automatic cyclic_step_selector_pkg::pos_t last_pos(
    input cyclic_step_selector_pkg::cnt_code_t code
  );
    cyclic_step_selector_pkg::pos_t res;
    unique case (code)
      cyclic_step_selector_pkg::CNT_TWO: res = cyclic_step_selector_pkg::LAST_TWO;
      cyclic_step_selector_pkg::CNT_THREE: res = cyclic_step_selector_pkg::LAST_THREE;
      cyclic_step_selector_pkg::CNT_FOUR: res = cyclic_step_selector_pkg::LAST_FOUR;
      cyclic_step_selector_pkg::CNT_DEFAULT: res = cyclic_step_selector_pkg::LAST_THREE;
    endcase
    return res;
  endfunction : last_pos

  // Next position with wrap at the last enabled one
  function automatic cyclic_step_selector_pkg::pos_t next_pos(
    input cyclic_step_selector_pkg::pos_t pos,
    input cyclic_step_selector_pkg::pos_t last
  );
    cyclic_step_selector_pkg::pos_t res;
    if (pos >= last) begin
      res = cyclic_step_selector_pkg::POS_FIRST;
    end else begin
      res = pos + 2'h1;
    end
    return res;
  endfunction : next_pos

  // Keep a position inside the enabled range, else fall back to the first
  function automatic cyclic_step_selector_pkg::pos_t clamp_pos(
    input cyclic_step_selector_pkg::pos_t pos,
    input cyclic_step_selector_pkg::pos_t last
  );
    cyclic_step_selector_pkg::pos_t res;
    if (pos > last) begin
      res = cyclic_step_selector_pkg::POS_FIRST;
    end else begin
      res = pos;
    end
    return res;
  endfunction : clamp_pos

  // One-hot decode of a position
  function automatic cyclic_step_selector_pkg::onehot_t decode_pos(
    input cyclic_step_selector_pkg::pos_t pos
  );
    cyclic_step_selector_pkg::onehot_t res;
    res = cyclic_step_selector_pkg::ONEHOT_RST;
    res[pos] = 1'b1;
    return res;
  endfunction : decode_pos

  // ------------------------------------------------------------------
  // Per-instance input bundling
  // ------------------------------------------------------------------
  logic [cyclic_step_selector_pkg::NUM_INST-1:0] step_in;
  cyclic_step_selector_pkg::cnt_code_t cnt_in [cyclic_step_selector_pkg::NUM_INST];
  cyclic_step_selector_pkg::pos_t nv_in [cyclic_step_selector_pkg::NUM_INST];

  // Instance A and B share one datapath, indexed by instance
  assign step_in[cyclic_step_selector_pkg::INST_A] = i_step_a;
  assign step_in[cyclic_step_selector_pkg::INST_B] = i_step_b;
  assign cnt_in[cyclic_step_selector_pkg::INST_A] = i_cnt_a;
  assign cnt_in[cyclic_step_selector_pkg::INST_B] = i_cnt_b;
  assign nv_in[cyclic_step_selector_pkg::INST_A] = i_nv_pos_a;
  assign nv_in[cyclic_step_selector_pkg::INST_B] = i_nv_pos_b;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  cyclic_step_selector_pkg::seq_state_e state_q;
  logic [cyclic_step_selector_pkg::NUM_INST-1:0] step_prev_q;
  logic [cyclic_step_selector_pkg::NUM_INST-1:0] step_rise;
  cyclic_step_selector_pkg::pos_t pos_q [cyclic_step_selector_pkg::NUM_INST];
  cyclic_step_selector_pkg::pos_t pos_d [cyclic_step_selector_pkg::NUM_INST];
  cyclic_step_selector_pkg::onehot_t onehot_q [cyclic_step_selector_pkg::NUM_INST];
  logic pos_changed;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------

  // One restore cycle after reset release, then run for good
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= cyclic_step_selector_pkg::ST_RESTORE;
    end else begin
      state_q <= cyclic_step_selector_pkg::ST_RUN;
    end
  end

  // ------------------------------------------------------------------
  // Step edge detection
  // ------------------------------------------------------------------

  // Previous step level; reset high so a level held at power-up is not a step
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_prev_q <= {cyclic_step_selector_pkg::NUM_INST{cyclic_step_selector_pkg::STEP_PREV_RST}};
    end else begin
      step_prev_q <= step_in;
    end
  end

  assign step_rise = step_in & ~step_prev_q;

  // ------------------------------------------------------------------
  // Position update
  // ------------------------------------------------------------------

  // Next position per instance; each sees only its own step and setting
  always_comb begin
    pos_changed = 1'b0;
    for (int i = 0; i < cyclic_step_selector_pkg::NUM_INST; i++) begin
      pos_d[i] = clamp_pos(pos_q[i], last_pos(cnt_in[i]));
      if (state_q == cyclic_step_selector_pkg::ST_RESTORE) begin
        if (i_nv_valid) begin
          pos_d[i] = clamp_pos(nv_in[i], last_pos(cnt_in[i]));
        end else begin
          pos_d[i] = cyclic_step_selector_pkg::POS_FIRST;
        end
      end else if (step_rise[i]) begin
        pos_d[i] = next_pos(pos_d[i], last_pos(cnt_in[i]));
      end
      if (pos_d[i] != pos_q[i]) begin
        pos_changed = 1'b1;
      end
    end
  end

  // Current positions
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < cyclic_step_selector_pkg::NUM_INST; i++) begin
        pos_q[i] <= cyclic_step_selector_pkg::POS_FIRST;
      end
    end else begin
      for (int i = 0; i < cyclic_step_selector_pkg::NUM_INST; i++) begin
        pos_q[i] <= pos_d[i];
      end
    end
  end

  // Position outputs decoded from the next value so they track pos_q exactly
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < cyclic_step_selector_pkg::NUM_INST; i++) begin
        onehot_q[i] <= cyclic_step_selector_pkg::ONEHOT_RST;
      end
    end else begin
      for (int i = 0; i < cyclic_step_selector_pkg::NUM_INST; i++) begin
        onehot_q[i] <= decode_pos(pos_d[i]);
      end
    end
  end

  // ------------------------------------------------------------------
  // Non-volatile write-back
  // ------------------------------------------------------------------

  // Any change, including a clamp after a setting change, is written back;
  // the restore cycle writes too so the store always holds a legal value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nv_wr <= 1'b0;
      o_nv_pos_a <= cyclic_step_selector_pkg::POS_FIRST;
      o_nv_pos_b <= cyclic_step_selector_pkg::POS_FIRST;
    end else begin
      o_nv_wr <= pos_changed || (state_q == cyclic_step_selector_pkg::ST_RESTORE);
      o_nv_pos_a <= pos_d[cyclic_step_selector_pkg::INST_A];
      o_nv_pos_b <= pos_d[cyclic_step_selector_pkg::INST_B];
    end
  end

  // ------------------------------------------------------------------
  // Output mapping
  // ------------------------------------------------------------------
  assign o_sel_a_pos1 = onehot_q[cyclic_step_selector_pkg::INST_A][0];
  assign o_sel_a_pos2 = onehot_q[cyclic_step_selector_pkg::INST_A][1];
  assign o_sel_a_pos3 = onehot_q[cyclic_step_selector_pkg::INST_A][2];
  assign o_sel_a_pos4 = onehot_q[cyclic_step_selector_pkg::INST_A][3];
  assign o_sel_b_pos1 = onehot_q[cyclic_step_selector_pkg::INST_B][0];
  assign o_sel_b_pos2 = onehot_q[cyclic_step_selector_pkg::INST_B][1];
  assign o_sel_b_pos3 = onehot_q[cyclic_step_selector_pkg::INST_B][2];
  assign o_sel_b_pos4 = onehot_q[cyclic_step_selector_pkg::INST_B][3];

endmodule : cyclic_step_selector

`default_nettype wire

// [sim/nv_store_model.sv]
// Behavioural non-volatile position store facing the selector
`timescale 1ns/100ps
`default_nettype none
module nv_store_model (
  // Clock
  input wire logic i_clk,
  // Write side from the selector
  input wire logic i_wr,
  input wire logic [1:0] i_pa,
  input wire logic [1:0] i_pb,
  // Read side to the selector
  output logic o_valid,
  output logic [1:0] o_pa,
  output logic [1:0] o_pb
);
  // Blank store at power up; no reset, contents outlive the selector's reset
  initial begin
    o_valid = 1'b0;
    o_pa = 2'h0;
    o_pb = 2'h1;
  end
  // Keep every write; an empty store shows churning data so nothing leans on it
  always @(posedge i_clk) begin
    if (i_wr) begin
      o_valid <= 1'b1;
      o_pa <= i_pa;
      o_pb <= i_pb;
    end else if (!o_valid) begin
      o_pa <= ~o_pa;
      o_pb <= ~o_pb;
    end
  end
endmodule : nv_store_model
`default_nettype wire

// [sim/cyclic_step_selector_checker.sv]
// Port assertions for the cyclic step selector
`timescale 1ns/100ps
`default_nettype none
module cyclic_step_selector_checker (
  // Clock, reset and inputs
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_step_a,
  input wire logic i_step_b,
  input wire logic [1:0] i_cnt_a,
  input wire logic [1:0] i_cnt_b,
  input wire logic i_nv_valid,
  // Outputs
  input wire logic o_nv_wr,
  input wire logic [1:0] o_nv_pos_a,
  input wire logic [1:0] o_nv_pos_b,
  input wire logic o_sel_a_pos1, o_sel_a_pos2, o_sel_a_pos3, o_sel_a_pos4,
  input wire logic o_sel_b_pos1, o_sel_b_pos2, o_sel_b_pos3, o_sel_b_pos4
);
  logic run_q;
  wire logic [3:0] va = {o_sel_a_pos4, o_sel_a_pos3, o_sel_a_pos2, o_sel_a_pos1};
  wire logic [3:0] vb = {o_sel_b_pos4, o_sel_b_pos3, o_sel_b_pos2, o_sel_b_pos1};
  // Last index of a count code; code 0 behaves as three
  function automatic logic [1:0] lst(input logic [1:0] c);
    return (c == 2'h1) ? 2'h1 : (c == 2'h3) ? 2'h3 : 2'h2;
  endfunction : lst
  // Next index; a position beyond last clamps to first, then steps
  function automatic logic [1:0] nxt(input logic [1:0] p, input logic [1:0] c);
    return (p > lst(c)) ? 2'h1 : (p == lst(c)) ? 2'h0 : p + 2'h1;
  endfunction : nxt
  // High once the restore edge has passed, so the restore cycle is excluded
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) run_q <= 1'b0;
    else run_q <= 1'b1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_onehot; run_q |-> $onehot(va) && $onehot(vb); endproperty
  a_onehot: assert property (p_onehot) else $error("outputs not one-hot");
  property p_map_a; run_q |-> va == (4'h1 << o_nv_pos_a); endproperty
  a_map_a: assert property (p_map_a) else $error("A output disagrees with position");
  property p_map_b; run_q |-> vb == (4'h1 << o_nv_pos_b); endproperty
  a_map_b: assert property (p_map_b) else $error("B output disagrees with position");
  property p_step_a; run_q && $rose(i_step_a) |=> o_nv_pos_a == nxt($past(o_nv_pos_a), $past(i_cnt_a)); endproperty
  a_step_a: assert property (p_step_a) else $error("A stepped wrongly");
  property p_step_b; run_q && $rose(i_step_b) |=> o_nv_pos_b == nxt($past(o_nv_pos_b), $past(i_cnt_b)); endproperty
  a_step_b: assert property (p_step_b) else $error("B stepped wrongly");
  property p_hold_a; run_q && !$rose(i_step_a) && o_nv_pos_a <= lst(i_cnt_a) |=> $stable(o_nv_pos_a); endproperty
  a_hold_a: assert property (p_hold_a) else $error("A moved without a step edge");
  property p_hold_b; run_q && !$rose(i_step_b) && o_nv_pos_b <= lst(i_cnt_b) |=> $stable(o_nv_pos_b); endproperty
  a_hold_b: assert property (p_hold_b) else $error("B moved without a step edge");
  property p_wr; run_q && $past(run_q) |-> o_nv_wr == ($changed(o_nv_pos_a) || $changed(o_nv_pos_b)); endproperty
  a_wr: assert property (p_wr) else $error("store write not tied to a move");
  property p_dflt; !run_q && !i_nv_valid |=> o_nv_wr && va == 4'h1 && vb == 4'h1; endproperty
  a_dflt: assert property (p_dflt) else $error("blank store did not give first position");
endmodule : cyclic_step_selector_checker
bind cyclic_step_selector cyclic_step_selector_checker cyclic_step_selector_checker_inst (.i_clk, .i_rst_n,
  .i_step_a, .i_step_b, .i_cnt_a, .i_cnt_b, .i_nv_valid, .o_nv_wr, .o_nv_pos_a, .o_nv_pos_b,
  .o_sel_a_pos1, .o_sel_a_pos2, .o_sel_a_pos3, .o_sel_a_pos4,
  .o_sel_b_pos1, .o_sel_b_pos2, .o_sel_b_pos3, .o_sel_b_pos4);
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the cyclic step selector
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, step_a = 1'b0, step_b = 1'b0;
  logic [1:0] cnt_a = 2'h0, cnt_b = 2'h0;
  wire logic nv_valid, nv_wr;
  wire logic [1:0] nv_pa, nv_pb, pos_a, pos_b;
  wire logic [3:0] va, vb;
  int fail_count = 0, n_tests = 0, ea = 0, eb = 0;
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  cyclic_step_selector cyclic_step_selector_inst (.i_clk(clk), .i_rst_n(rst_n), .i_step_a(step_a),
    .i_step_b(step_b), .i_cnt_a(cnt_a), .i_cnt_b(cnt_b), .i_nv_valid(nv_valid), .i_nv_pos_a(nv_pa),
    .i_nv_pos_b(nv_pb), .o_nv_wr(nv_wr), .o_nv_pos_a(pos_a), .o_nv_pos_b(pos_b),
    .o_sel_a_pos1(va[0]), .o_sel_a_pos2(va[1]), .o_sel_a_pos3(va[2]), .o_sel_a_pos4(va[3]),
    .o_sel_b_pos1(vb[0]), .o_sel_b_pos2(vb[1]), .o_sel_b_pos3(vb[2]), .o_sel_b_pos4(vb[3]));
  nv_store_model nv_store_model_inst (.i_clk(clk), .i_wr(nv_wr), .i_pa(pos_a), .i_pb(pos_b),
    .o_valid(nv_valid), .o_pa(nv_pa), .o_pb(nv_pb));
  // Compare one selector's outputs against an expected one-hot
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Expected next index; code 0 counts as three outputs
  function automatic int adv(input int p, input logic [1:0] c);
    return (p == ((c == 2'h1) ? 1 : (c == 2'h3) ? 3 : 2)) ? 0 : p + 1;
  endfunction : adv
  // Reset, optionally with step A held high across release and A's count changed
  // while in reset; the store survives, so a stale position must be clamped on restore
  task automatic do_reset(input logic hold, input logic [1:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    step_a <= hold;
    cnt_a <= c;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(va, 4'(1 << ea));
    chk(vb, 4'(1 << eb));
    chk({pos_b, pos_a}, {2'(eb), 2'(ea)});
  endtask : do_reset
  // One pulse on the chosen inputs; low again before the next, so each is an edge
  task automatic step(input logic a, input logic b);
    @(posedge clk);
    step_a <= a;
    step_b <= b;
    @(posedge clk);
    step_a <= 1'b0;
    step_b <= 1'b0;
    if (a) ea = adv(ea, cnt_a);
    if (b) eb = adv(eb, cnt_b);
    #1;
    chk(va, 4'(1 << ea));
    chk(vb, 4'(1 << eb));
  endtask : step
  // Blank store gives first position; unconfigured wraps after three
  task automatic t_default;
    do_reset(1'b0, 2'h0);
    repeat (3) step(1'b1, 1'b1);
    $display("t_default done");
  endtask : t_default
  // Count codes 1 to 3, A and B set differently except both at 2, plus A-only steps
  task automatic t_counts;
    for (int c = 1; c < 4; c++) begin
      @(posedge clk);
      cnt_a <= 2'(c);
      cnt_b <= 2'(4 - c);
      repeat (4) step(1'b1, 1'b1);
      step(1'b1, 1'b0);
    end
    $display("t_counts done");
  endtask : t_counts
  // A held step advances once only
  task automatic t_hold;
    @(posedge clk);
    step_a <= 1'b1;
    repeat (5) @(posedge clk);
    step_a <= 1'b0;
    ea = adv(ea, cnt_a);
    #1;
    chk(va, 4'(1 << ea));
    $display("t_hold done");
  endtask : t_hold
  // Lowering the count below the current position falls back to the first and is saved
  task automatic t_shrink;
    step(1'b1, 1'b0);
    @(posedge clk);
    cnt_a <= 2'h1;
    ea = 0;
    @(posedge clk);
    #1;
    chk(va, 4'(1 << ea));
    chk({3'h0, nv_wr}, 4'h1);
    step(1'b1, 1'b0);
    $display("t_shrink done");
  endtask : t_shrink
  // Power cycle resumes stored positions; a stored position beyond a lowered count restores as first
  task automatic t_power;
    do_reset(1'b1, 2'h1);
    @(posedge clk);
    step_a <= 1'b0;
    cnt_a <= 2'h3;
    repeat (2) step(1'b1, 1'b0);
    ea = 0;
    do_reset(1'b0, 2'h1);
    $display("t_power done");
  endtask : t_power
  // Verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    t_default();
    t_counts();
    t_hold();
    t_shrink();
    t_power();
    test_done();
  end
  // Watchdog well beyond the 83 cycles the tests need
  initial begin
    #4000;
    fail_count++;
    test_done();
  end
endmodule : tb
`default_nettype wire
